// file: design/utdts_top.sv
// UART transmit DMA channel time-out and termination status with APB registers
//
// Functional notes
// - Short packet detected sets short-packet flag bit 0
// - Short-packet flag clears only on write of 1
// - Completion interrupt off: flags keep channel enabled
// - Bit 1 reads 1 after time-out stop
// - Time-out flag clears only on write of 1
// - Bits 6 to 2 hold time-out in ms
// - Every byte transfer while counting is enabled reloads the down counter
// - Counter decrements once per frame tick
// - Counter at zero sets flag, halts transfer
// - Counts only when enabled, after first byte
// - Bit 7 enables the time-out counter
// - Short packet reports time-out 0, short 1
// - Time-out reports time-out 1, short 0
// - Termination clears channel enable; falling edge interrupts when completion interrupt is on
// - Packet under 64 bytes is a short packet
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "utdts_defines.svh"
module utdts_top
   import utdts_pkg::*;
#(
   parameter int AW = 20,
   parameter int CW = 5,
   parameter int PKT_BYTES = `UTDTS_FULL_PKT_BYTES
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic byteXfer,
   input wire logic sofTick,
   input wire logic pktDone,
   input wire logic [7:0] pktByteCount,
   input wire logic xferComplete,
   output logic channelEnable,
   output logic completionIrq,
   output logic dmaHalt,
   output logic shortPacketFlag,
   output logic transferTimeoutFlag,
   output logic timeoutCounting
);

   // Field width is fixed by the register layout
   if (CW != `UTDTS_TOV_MSB - `UTDTS_TOV_LSB + 1) begin : g_cw_check
      $error("utdts_top: CW must match the time-out field width");
   end
   if (PKT_BYTES < 1 || PKT_BYTES > 255) begin : g_pkt_check
      $error("utdts_top: PKT_BYTES must be 1 to 255");
   end

   // Bus side
   logic wrStrobe;
   logic rdCapture;
   logic selCsr;
   logic selChan;
   logic selStat;
   logic wrCsr;
   logic wrChan;

   // Control and status state
   logic tcEnable_q;
   logic tcEnable_d;
   logic [CW-1:0] timeoutValue_q;
   logic [CW-1:0] timeoutValue_d;
   logic spf_q;
   logic spf_d;
   logic ttf_q;
   logic ttf_d;
   logic chanEn_q;
   logic chanEn_d;
   logic cie_q;
   logic cie_d;
   utdts_cause_t cause_q;
   utdts_cause_t cause_d;
   logic irq_q;
   logic irq_d;
   logic halt_q;
   logic halt_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // Events
   logic countEnable;
   logic expired;
   logic running;
   logic [CW-1:0] count;
   logic shortPkt;
   logic spfSet;
   logic ttfSet;
   logic doneEvt;
   logic spfClr;
   logic ttfClr;
   logic flagStop;
   logic termClear;

   // Read views
   logic [7:0] csrView;
   logic [7:0] chanView;
   logic [7:0] statView;
   logic [31:0] rdWord;

   utdts_apb_slave #(
      .AW(AW)
   ) u_apb (
      .clk_sys(clk_sys),
      .reset(reset),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(pready),
      .pslverr(pslverr),
      .wrStrobe(wrStrobe),
      .rdCapture(rdCapture),
      .selCsr(selCsr),
      .selChan(selChan),
      .selStat(selStat)
   );

   assign wrCsr = wrStrobe && selCsr;
   assign wrChan = wrStrobe && selChan;

   // Counter runs only with both enables set
   assign countEnable = tcEnable_q && chanEn_q;

   utdts_timeout_counter #(
      .CW(CW)
   ) u_tmr (
      .clk_sys(clk_sys),
      .reset(reset),
      .countEnable(countEnable),
      .reloadValue(timeoutValue_q),
      .byteXfer(byteXfer),
      .sofTick(sofTick),
      .expired(expired),
      .running(running),
      .count(count)
   );

   // Short packet only counts while the channel is live
   assign shortPkt = pktDone && (pktByteCount < 8'(PKT_BYTES));

   // Time-out wins a same-cycle tie so only one code is reported
   assign ttfSet = expired;
   assign spfSet = chanEn_q && shortPkt && !expired;
   // Completion ends the channel even when a flag event ties with it
   assign doneEvt = chanEn_q && xferComplete;

   // Write-one-to-clear; a same-cycle set still wins
   assign spfClr = wrCsr && pwdata[`UTDTS_SPF_BIT];
   assign ttfClr = wrCsr && pwdata[`UTDTS_TTF_BIT];
   assign spf_d = spfSet || (spf_q && !spfClr);
   assign ttf_d = ttfSet || (ttf_q && !ttfClr);

   // Field writes for time-out value and counter enable
   assign timeoutValue_d = wrCsr ? pwdata[`UTDTS_TOV_MSB:`UTDTS_TOV_LSB]
      : timeoutValue_q;
   assign tcEnable_d = wrCsr ? pwdata[`UTDTS_TCE_BIT] : tcEnable_q;
   assign cie_d = wrChan ? pwdata[`UTDTS_CIE_BIT] : cie_q;

   // Flags end the channel only with completion interrupt on
   assign flagStop = cie_q && (spfSet || ttfSet);
   assign termClear = flagStop || doneEvt;

   // Hardware termination beats a same-cycle software enable write
   assign chanEn_d = termClear ? 1'b0
      : wrChan ? pwdata[`UTDTS_CEN_BIT]
      : chanEn_q;

   // Falling enable raises a one-cycle completion interrupt when the completion interrupt enable is set
   assign irq_d = cie_q && chanEn_q && !chanEn_d;

   // Halt pulse stops the datapath on any flagged termination
   assign halt_d = ttfSet || spfSet;

   assign cause_d = ttfSet ? UTDTS_CAUSE_TIMEOUT
      : spfSet ? UTDTS_CAUSE_SHORT
      : doneEvt ? UTDTS_CAUSE_DONE
      : cause_q;

   // Register read views, unused bits read zero
   assign csrView = {tcEnable_q, timeoutValue_q, ttf_q, spf_q};
   assign chanView = {chanEn_q, cie_q, 6'h00};
   assign statView = {cause_q, running, count};

   always_comb begin
      rdWord = 32'h0000_0000;
      if (selCsr) begin
         rdWord = {24'h00_0000, csrView};
      end else if (selChan) begin
         rdWord = {24'h00_0000, chanView};
      end else if (selStat) begin
         rdWord = {24'h00_0000, statView};
      end
   end

   assign prdata_d = rdCapture ? rdWord : prdata_q;

   // Counter enable field of the control register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tcEnable_q <= 1'b0;
      end else begin
         tcEnable_q <= tcEnable_d;
      end
   end

   // Reload value; a change applies at the next byte
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timeoutValue_q <= '0;
      end else begin
         timeoutValue_q <= timeoutValue_d;
      end
   end

   // Short-packet flag, sticky until written with one
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         spf_q <= 1'b0;
      end else begin
         spf_q <= spf_d;
      end
   end

   // Time-out flag, sticky until written with one
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ttf_q <= 1'b0;
      end else begin
         ttf_q <= ttf_d;
      end
   end

   // Channel enable, cleared by any termination
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         chanEn_q <= 1'b0;
      end else begin
         chanEn_q <= chanEn_d;
      end
   end

   // Completion interrupt enable
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cie_q <= 1'b0;
      end else begin
         cie_q <= cie_d;
      end
   end

   // Last termination cause, kept for status reads
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cause_q <= UTDTS_CAUSE_NONE;
      end else begin
         cause_q <= cause_d;
      end
   end

   // One-cycle interrupt pulse, not a level
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Halt pulse to the transfer datapath
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= halt_d;
      end
   end

   // Read data held until the next read capture
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign channelEnable = chanEn_q;
   assign completionIrq = irq_q;
   assign dmaHalt = halt_q;
   assign shortPacketFlag = spf_q;
   assign transferTimeoutFlag = ttf_q;
   assign timeoutCounting = running;

endmodule // utdts_top

// file: design/utdts_defines.svh
// Register map, field positions, reset values and timing for the UART transmit DMA time-out block
`ifndef UTDTS_DEFINES_SVH
`define UTDTS_DEFINES_SVH

// Register indices; byte address is four times the index
`define UTDTS_CSR_INDEX 18'h0_ffe1
`define UTDTS_CHAN_INDEX 18'h0_ff00
`define UTDTS_STAT_INDEX 18'h0_ff01
`define UTDTS_CSR_ADDR {`UTDTS_CSR_INDEX, 2'b00}
`define UTDTS_CHAN_ADDR {`UTDTS_CHAN_INDEX, 2'b00}
`define UTDTS_STAT_ADDR {`UTDTS_STAT_INDEX, 2'b00}

// Control and status register fields
`define UTDTS_SPF_BIT 0
`define UTDTS_TTF_BIT 1
`define UTDTS_TOV_LSB 2
`define UTDTS_TOV_MSB 6
`define UTDTS_TCE_BIT 7
`define UTDTS_CSR_RESET 8'h00

// Channel control register fields
`define UTDTS_CIE_BIT 6
`define UTDTS_CEN_BIT 7
`define UTDTS_CHAN_RESET 8'h00

// Status register fields
`define UTDTS_STAT_CNT_LSB 0
`define UTDTS_STAT_CNT_MSB 4
`define UTDTS_STAT_RUN_BIT 5
`define UTDTS_STAT_CAUSE_LSB 6
`define UTDTS_STAT_CAUSE_MSB 7

// Timing and packet limits
`define UTDTS_TIMEOUT_STEP_MS 1
`define UTDTS_SOF_PERIOD_MS 1
`define UTDTS_FULL_PKT_BYTES 64

`endif

// file: design/utdts_pkg.sv
// Types shared by the UART transmit DMA time-out block
package utdts_pkg;

   typedef enum logic {
      UTDTS_WAIT_FIRST,
      UTDTS_COUNTING
   } utdts_tmr_state_t;

   typedef enum logic [1:0] {
      UTDTS_CAUSE_NONE,
      UTDTS_CAUSE_DONE,
      UTDTS_CAUSE_SHORT,
      UTDTS_CAUSE_TIMEOUT
   } utdts_cause_t;

endpackage

// file: design/utdts_timeout_counter.sv
// Transaction time-out down counter clocked by frame ticks
`timescale 1ns/1ps
module utdts_timeout_counter
   import utdts_pkg::*;
#(
   parameter int CW = 5
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic countEnable,
   input wire logic [CW-1:0] reloadValue,
   input wire logic byteXfer,
   input wire logic sofTick,
   output logic expired,
   output logic running,
   output logic [CW-1:0] count
);

   if (CW < 1) begin : g_cw_check
      $error("utdts_timeout_counter: CW must be at least 1");
   end

   utdts_tmr_state_t state_q;
   utdts_tmr_state_t state_d;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic lastStep;

   // A zero reload expires on the next tick, like a one
   assign lastStep = (count_q <= CW'(1));
   assign expired = (state_q == UTDTS_COUNTING) && countEnable && !byteXfer
      && sofTick && lastStep;
   assign running = (state_q == UTDTS_COUNTING);
   assign count = count_q;

   always_comb begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         UTDTS_WAIT_FIRST: begin
            if (countEnable && byteXfer) begin
               state_d = UTDTS_COUNTING;
               count_d = reloadValue;
            end
         end
         UTDTS_COUNTING: begin
            if (!countEnable) begin
               state_d = UTDTS_WAIT_FIRST;
            end else if (byteXfer) begin
               count_d = reloadValue;
            end else if (sofTick) begin
               if (lastStep) begin
                  state_d = UTDTS_WAIT_FIRST;
                  count_d = '0;
               end else begin
                  count_d = count_q - CW'(1);
               end
            end
         end
         default: begin
            state_d = UTDTS_WAIT_FIRST;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= UTDTS_WAIT_FIRST;
         count_q <= '0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

endmodule // utdts_timeout_counter

// file: design/utdts_apb_slave.sv
// APB decode and handshake for the time-out block registers
`timescale 1ns/1ps
`include "utdts_defines.svh"
module utdts_apb_slave
   import utdts_pkg::*;
#(
   parameter int AW = 20
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   output logic pready,
   output logic pslverr,
   output logic wrStrobe,
   output logic rdCapture,
   output logic selCsr,
   output logic selChan,
   output logic selStat
);

   if (AW < 20) begin : g_aw_check
      $error("utdts_apb_slave: AW must be at least 20");
   end

   logic ready_q;
   logic mapped;

   assign selCsr = (paddr == AW'(`UTDTS_CSR_ADDR));
   assign selChan = (paddr == AW'(`UTDTS_CHAN_ADDR));
   assign selStat = (paddr == AW'(`UTDTS_STAT_ADDR));
   assign mapped = selCsr || selChan || selStat;

   // One wait state so read data comes from a flop
   assign rdCapture = psel && penable && !ready_q;
   assign pready = ready_q;
   assign pslverr = ready_q && !mapped;
   assign wrStrobe = psel && penable && ready_q && pwrite && mapped;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= rdCapture;
      end
   end

endmodule // utdts_apb_slave

// file: verification/utdts_props.sv
// Port assertions for the UART transmit DMA time-out block
`timescale 1ns/1ps
`include "utdts_defines.svh"
module utdts_props #(
   parameter int AW = 20,
   parameter int PKT_BYTES = 64
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic byteXfer,
   input wire logic sofTick,
   input wire logic pktDone,
   input wire logic [7:0] pktByteCount,
   input wire logic xferComplete,
   input wire logic channelEnable,
   input wire logic completionIrq,
   input wire logic dmaHalt,
   input wire logic shortPacketFlag,
   input wire logic transferTimeoutFlag,
   input wire logic timeoutCounting
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   wire csrWr = psel && penable && pready && pwrite && paddr == `UTDTS_CSR_ADDR;
   wire spfClrWr = csrWr && pwdata[`UTDTS_SPF_BIT];
   wire ttfClrWr = csrWr && pwdata[`UTDTS_TTF_BIT];
   // A tick in the same cycle may expire the counter, which wins
   sequence shortArrive;
      pktDone && pktByteCount < PKT_BYTES && channelEnable && !sofTick;
   endsequence
   // Expiry needs an armed counter and a tick one cycle before
   sequence tmoEffect;
      $past(sofTick) && $past(timeoutCounting) && dmaHalt && !$rose(shortPacketFlag);
   endsequence
   a_short_set: assert property (shortArrive |=> shortPacketFlag)
      else $error("short flag not set");
   a_short_hold: assert property (shortPacketFlag && !spfClrWr |=> shortPacketFlag)
      else $error("short flag lost");
   a_short_clear: assert property (spfClrWr && !pktDone |=> !shortPacketFlag)
      else $error("short flag not cleared");
   a_tmo_hold: assert property (transferTimeoutFlag && !ttfClrWr |=> transferTimeoutFlag)
      else $error("time-out flag lost");
   a_tmo_clear: assert property (ttfClrWr && !sofTick |=> !transferTimeoutFlag)
      else $error("time-out flag not cleared");
   a_tmo_cause: assert property ($rose(transferTimeoutFlag) |-> tmoEffect)
      else $error("time-out without tick");
   a_arm_byte: assert property ($rose(timeoutCounting) |-> $past(byteXfer))
      else $error("counter armed without byte");
   a_idle_off: assert property (!channelEnable [*2] |-> !timeoutCounting)
      else $error("counting while disabled");
   a_irq_fall: assert property (completionIrq |-> $fell(channelEnable))
      else $error("irq without enable fall");
   a_done_clr: assert property (xferComplete && channelEnable |=> !channelEnable)
      else $error("enable kept after completion");
   a_halt_flag: assert property (dmaHalt |-> transferTimeoutFlag || shortPacketFlag)
      else $error("halt without cause");
endmodule // utdts_props

bind utdts_top utdts_props #(
   .AW(AW),
   .PKT_BYTES(PKT_BYTES)
) u_props (
   .clk_sys(clk_sys),
   .reset(reset),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .byteXfer(byteXfer),
   .sofTick(sofTick),
   .pktDone(pktDone),
   .pktByteCount(pktByteCount),
   .xferComplete(xferComplete),
   .channelEnable(channelEnable),
   .completionIrq(completionIrq),
   .dmaHalt(dmaHalt),
   .shortPacketFlag(shortPacketFlag),
   .transferTimeoutFlag(transferTimeoutFlag),
   .timeoutCounting(timeoutCounting)
);

// file: verification/utdts_event_model.sv
// Host traffic and frame-tick source facing the time-out block
`timescale 1ns/1ps
module utdts_event_model (
   input wire logic clk_sys,
   output logic byteXfer,
   output logic sofTick,
   output logic pktDone,
   output logic [7:0] pktByteCount,
   output logic xferComplete
);
   initial begin
      {xferComplete, pktDone, sofTick, byteXfer} = 4'h0;
      pktByteCount = 8'h00;
   end
   // Ticks far closer than 1 ms to keep runs short
   task automatic send(input logic [3:0] kind, input logic [7:0] n);
      @(posedge clk_sys);
      {xferComplete, pktDone, sofTick, byteXfer} <= kind;
      pktByteCount <= n;
      @(posedge clk_sys);
      {xferComplete, pktDone, sofTick, byteXfer} <= 4'h0;
      pktByteCount <= ~n; // Count not held after its pulse
   endtask
endmodule // utdts_event_model

// file: verification/uart_tx_dma_timeout_status_tb.sv
// Self-checking bench for the UART transmit DMA time-out block
`timescale 1ns/1ps
`include "utdts_defines.svh"
module uart_tx_dma_timeout_status_tb;
   import utdts_pkg::*;
   localparam logic [19:0] CSR = `UTDTS_CSR_ADDR;
   localparam logic [19:0] CHAN = `UTDTS_CHAN_ADDR;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, errQ;
   logic byteXfer, sofTick, pktDone, xferComplete, channelEnable, completionIrq, dmaHalt;
   logic shortPacketFlag, transferTimeoutFlag, timeoutCounting;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd, lfsrState;
   logic [7:0] pktByteCount, n;
   logic [4:0] v;
   int error_cnt = 0;
   int samples_checked = 0;

   utdts_top DUT (.*);
   utdts_event_model HOST (.*);

   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h8020_0003)};
      return lfsrState;
   endfunction

   function automatic logic [31:0] csrVal(input logic tce, input logic [4:0] t,
      input logic [1:0] f);
      return {24'h00_0000, tce, t, f};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      errQ = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 20) chk(0, 1);
   endtask

   task automatic runTmo(input logic tce, input logic [31:0] chan);
      v = 5'(2 + rnd() % 30);
      apb(1, CHAN, chan);
      apb(1, CSR, csrVal(tce, v, 2'b00));
      HOST.send(4'h1, 8'h00);
      #1 chk(timeoutCounting, tce);
      repeat (v - 1) HOST.send(4'h2, 8'h00);
      HOST.send(4'h1, 8'h00);
      repeat (v - 1) HOST.send(4'h2, 8'h00);
      #1 chk(transferTimeoutFlag, 0);
      HOST.send(4'h2, 8'h00);
      #1 chk({transferTimeoutFlag, shortPacketFlag}, {tce, 1'b0});
      chk(dmaHalt, tce);
      chk(completionIrq, tce && chan[6]);
      chk(channelEnable, !(tce && chan[6]));
      chk(timeoutCounting, 0);
      apb(0, CSR, 0);
      chk(rd, csrVal(tce, v, {tce, 1'b0}));
      apb(1, CSR, csrVal(tce, v, 2'b00));
      #1 chk(transferTimeoutFlag, tce);
      apb(1, CSR, csrVal(tce, v, 2'b10));
      apb(0, CSR, 0);
      chk(rd, csrVal(tce, v, 2'b00));
      $display("test time-out %0b %h done", tce, chan[7:0]);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #300_000;
      chk(0, 1);
      print_verdict();
   end

   initial begin
      reset = 1;
      {psel, penable, pwrite} = 3'b000;
      paddr = 0;
      pwdata = 0;
      lfsrState = 32'h0000_d867;
      repeat (8) @(posedge clk_sys);
      reset <= 0;
      for (int i = 0; i < 3; i++) begin
         apb(0, CHAN + 20'(4 * i), 0);
         chk(rd, 0);
      end
      apb(0, CSR, 0);
      chk(rd, 0);
      apb(1, 20'h0_0010, 32'h0000_00ff);
      apb(0, 20'h0_0010, 0);
      chk({rd[0], errQ}, 2'b01);
      $display("test reset and decode done");
      runTmo(1, 32'h0000_00c0);
      runTmo(1, 32'h0000_0080);
      runTmo(0, 32'h0000_00c0);
      apb(1, CHAN, 32'h0000_0080);
      for (int i = 0; i < 4; i++) begin
         n = (i == 0) ? 8'h40 : (i == 1) ? 8'h3f : 8'(rnd() % 64);
         HOST.send(4'h4, n);
         #1 chk({transferTimeoutFlag, shortPacketFlag}, {1'b0, n < 64});
         chk(channelEnable, 1);
         apb(1, CSR, 0);
         #1 chk(shortPacketFlag, n < 64);
         apb(1, CSR, 1);
         #1 chk(shortPacketFlag, 0);
      end
      $display("test short packet done");
      apb(1, CHAN, 32'h0000_00c0);
      HOST.send(4'h8, 8'h00);
      #1 chk(channelEnable, 0);
      chk(completionIrq, 1);
      $display("test completion done");
      print_verdict();
   end
endmodule // uart_tx_dma_timeout_status_tb
